// File: include/fra_pkg.sv
// Shared constants and carrier types of the receive-side frame reassembler
package fra_pkg;

  // Frame layout in octets
  localparam int LEN_BYTES = 2;
  localparam int CRC_BYTES = 4;
  localparam int MARKER_BYTES = 4;
  localparam int PAD_ALIGN = 4;
  localparam int MIN_ULPDU = 128;
  // Smallest legal store: payload plus pad, length, check value and a marker
  localparam int MIN_STORE = 140;

  // Default sizing
  localparam int DEF_DEPTH = 2048;
  localparam int DEF_LINK_MTU = 1500;
  localparam int DEF_MARKER_SPACING = 512;

  // CRC32C, reflected form
  localparam logic [31:0] CRC_POLY = 32'h82F63B78;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  // One byte of a validated transport segment
  typedef struct packed {
    logic sop;
    logic [31:0] seq;
    logic [7:0] data;
    logic csum_ok;
    logic in_window;
    logic epoch_ok;
  } fra_seg_t;

  // One byte of a validated frame payload towards the placement layer
  typedef struct packed {
    logic first;
    logic last;
    logic [31:0] seq;
    logic [7:0] data;
  } fra_pdu_t;

  typedef enum logic [2:0] {
    ST_HDR,
    ST_SCAN,
    ST_RXCRC,
    ST_EMIT,
    ST_FAIL
  } fra_st_t;

  typedef struct packed {
    fra_st_t st;
    logic [31:0] fs;
    logic [31:0] p;
    logic [31:0] fend;
    logic [16:0] cnt;
    logic [15:0] len;
    logic [16:0] k;
    logic [31:0] crc;
    logic [23:0] rx;
    logic pdu_v;
    fra_pdu_t pdu;
    logic dlv_pend;
    logic [31:0] dlv_end;
    logic deliver;
    logic icmp;
    logic sack;
    logic crc_err;
    logic [31:0] next_exp;
    logic dont_frag;
  } fra_state_t;

endpackage

// File: rtl/fra_reassembler.sv
// Receive-side frame reassembly over a TCP byte stream
`timescale 1ns/1ns

module fra_reassembler #(
  parameter int DEPTH = fra_pkg::DEF_DEPTH,
  parameter int LINK_MTU = fra_pkg::DEF_LINK_MTU,
  parameter int MARKER_SPACING = fra_pkg::DEF_MARKER_SPACING
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // Transport side
  input wire logic I_SEG_VALID,
  input wire fra_pkg::fra_seg_t I_SEG,
  input wire logic I_SEG_IP_FRAG,
  input wire logic I_TS_ENABLE,
  input wire logic [31:0] I_RCV_LEFT_EDGE,
  // Stream configuration
  input wire logic I_MARKER_ENABLE,
  input wire logic [31:0] I_STREAM_ISN,
  // Placement layer
  output logic O_PDU_VALID,
  output fra_pkg::fra_pdu_t O_PDU,
  input wire logic I_PDU_READY,
  output logic O_DELIVER,
  output logic [31:0] O_DELIVER_SEQ,
  // Status
  output logic O_DONT_FRAGMENT,
  output logic O_ICMP_FRAG_NEEDED,
  output logic O_SACK_HINT,
  output logic O_CRC_ERROR,
  output logic O_STREAM_FAIL
);

  localparam int AW = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (DEPTH < fra_pkg::MIN_STORE) begin : g_small
    $error("store depth below minimum frame size");
  end
  if (DEPTH < LINK_MTU) begin : g_mtu
    $error("store depth below link MTU");
  end
  if ((DEPTH & (DEPTH - 1)) != 0 || (MARKER_SPACING & (MARKER_SPACING - 1)) != 0) begin : g_pow2
    $error("depth and marker spacing must be powers of two");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ fra_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Marker positions counted from stream start
  function automatic logic is_marker(input logic [31:0] seq);
    logic [31:0] rel;
    rel = (seq - I_STREAM_ISN) & 32'(MARKER_SPACING - 1);
    return I_MARKER_ENABLE && (rel < 32'(fra_pkg::MARKER_BYTES));
  endfunction

  // Length field plus payload, padded to the alignment
  function automatic logic [16:0] padded_ext(input logic [15:0] len);
    logic [16:0] raw;
    raw = {1'b0, len} + 17'(fra_pkg::LEN_BYTES + fra_pkg::PAD_ALIGN - 1);
    return raw & ~17'(fra_pkg::PAD_ALIGN - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Byte store

  logic [7:0] mem [DEPTH];
  logic [DEPTH-1:0] vld;
  logic wr_en;
  logic clr_en;
  logic [AW-1:0] wa;
  logic [AW-1:0] ra;
  logic [7:0] rbyte;
  logic have;

  fra_pkg::fra_state_t q;
  fra_pkg::fra_state_t d;

  assign wa = I_SEG.seq[AW-1:0];
  assign ra = q.p[AW-1:0];
  assign rbyte = mem[ra];
  assign have = vld[ra];

  // Storage has no reset; only the presence bits are cleared
  always_ff @(posedge I_CLOCK) begin
    if (wr_en) begin
      mem[wa] <= I_SEG.data;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      vld <= '0;
    end else begin
      if (wr_en) begin
        vld[wa] <= 1'b1;
      end
      if (clr_en) begin
        vld[ra] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic seg_ok;
  logic [31:0] off;
  logic mark;
  logic [16:0] ext;
  logic [15:0] nlen;
  logic [31:0] edge_diff;

  always_comb begin
    d = q;
    d.deliver = 1'b0;
    d.icmp = 1'b0;
    d.sack = 1'b0;
    d.crc_err = 1'b0;
    wr_en = 1'b0;
    clr_en = 1'b0;
    ext = '0;
    nlen = '0;
    seg_ok = I_SEG.csum_ok && I_SEG.in_window && (!I_TS_ENABLE || I_SEG.epoch_ok);
    off = I_SEG.seq - q.fs;
    mark = is_marker(q.p);
    edge_diff = I_RCV_LEFT_EDGE - q.dlv_end;

    if (I_SEG_VALID && I_SEG_IP_FRAG) begin
      d.icmp = I_SEG.sop;
    end else if (I_SEG_VALID && seg_ok) begin
      // No overwrite of held or consumed bytes
      // Out-of-order bytes buffered
      // Emitted bytes have lost their presence bit; a late copy must not refill them
      if (off < 32'(DEPTH) && !vld[wa]
          && !(q.st == fra_pkg::ST_EMIT && off < q.p - q.fs)) begin
        wr_en = 1'b1;
      end
      if (I_SEG.sop && I_SEG.seq != q.next_exp) begin
        d.sack = 1'b1;
      end
      d.next_exp = I_SEG.seq + 32'h00000001;
    end

    if (q.pdu_v && I_PDU_READY) begin
      d.pdu_v = 1'b0;
    end

    if (q.dlv_pend && !edge_diff[31]) begin
      d.deliver = 1'b1;
      d.dlv_pend = 1'b0;
    end

    unique case (q.st)
      fra_pkg::ST_HDR: begin
        // Length field taken from the two bytes at the frame start, markers skipped
        if (have) begin
          d.p = q.p + 32'h00000001;
          if (!mark) begin
            d.crc = crc_byte(q.crc, rbyte);
            d.len = {q.len[7:0], rbyte};
            d.cnt = q.cnt + 17'h00001;
            if (q.cnt == 17'h00001) begin
              nlen = {q.len[7:0], rbyte};
              ext = padded_ext(nlen);
              if (ext + 17'(fra_pkg::CRC_BYTES) > 17'(DEPTH)) begin
                d.st = fra_pkg::ST_FAIL;
              end else begin
                d.st = fra_pkg::ST_SCAN;
                d.cnt = ext - 17'(fra_pkg::LEN_BYTES);
              end
            end
          end
        end
      end
      fra_pkg::ST_SCAN: begin
        // Join pieces until the frame is whole
        if (have) begin
          d.p = q.p + 32'h00000001;
          if (!mark) begin
            d.crc = crc_byte(q.crc, rbyte);
            d.cnt = q.cnt - 17'h00001;
            if (q.cnt == 17'h00001) begin
              d.st = fra_pkg::ST_RXCRC;
              d.cnt = 17'(fra_pkg::CRC_BYTES);
            end
          end
        end
      end
      fra_pkg::ST_RXCRC: begin
        if (have) begin
          d.p = q.p + 32'h00000001;
          if (!mark) begin
            d.rx = {q.rx[15:0], rbyte};
            d.cnt = q.cnt - 17'h00001;
            if (q.cnt == 17'h00001) begin
              if ({q.rx, rbyte} == ~q.crc) begin
                d.st = fra_pkg::ST_EMIT;
                d.fend = q.p + 32'h00000001;
                d.p = q.fs;
                d.k = '0;
              end else begin
                d.crc_err = 1'b1;
                d.st = fra_pkg::ST_FAIL;
              end
            end
          end
        end
      end
      fra_pkg::ST_EMIT: begin
        if (!d.pdu_v) begin
          if (q.p == q.fend) begin
            if (!q.dlv_pend) begin
              d.dlv_pend = 1'b1;
              d.dlv_end = q.fend;
              d.fs = q.fend;
              d.cnt = '0;
              d.crc = fra_pkg::CRC_INIT;
              d.st = fra_pkg::ST_HDR;
            end
          end else begin
            clr_en = 1'b1;
            d.p = q.p + 32'h00000001;
            if (!mark) begin
              d.k = q.k + 17'h00001;
              if (q.k >= 17'(fra_pkg::LEN_BYTES)
                  && q.k < {1'b0, q.len} + 17'(fra_pkg::LEN_BYTES)) begin
                d.pdu_v = 1'b1;
                d.pdu.data = rbyte;
                d.pdu.seq = q.p;
                d.pdu.first = (q.k == 17'(fra_pkg::LEN_BYTES));
                d.pdu.last = (q.k == {1'b0, q.len} + 17'(fra_pkg::LEN_BYTES - 1));
              end
            end
          end
        end
      end
      fra_pkg::ST_FAIL: begin
        d.st = fra_pkg::ST_FAIL;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      q <= '0;
      q.crc <= fra_pkg::CRC_INIT;
      q.st <= fra_pkg::ST_HDR;
      q.dont_frag <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign O_PDU_VALID = q.pdu_v;
  assign O_PDU = q.pdu;
  assign O_DELIVER = q.deliver;
  assign O_DELIVER_SEQ = q.dlv_end;
  assign O_DONT_FRAGMENT = q.dont_frag;
  assign O_ICMP_FRAG_NEEDED = q.icmp;
  assign O_SACK_HINT = q.sack;
  assign O_CRC_ERROR = q.crc_err;
  assign O_STREAM_FAIL = (q.st == fra_pkg::ST_FAIL);

endmodule // fra_reassembler

// File: testbench/fra_reassembler_props.sv
// Port checks for the frame reassembler
`timescale 1ns/1ns
module fra_reassembler_props (
  // Clock, reset and transport side
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_SEG_VALID,
  input wire fra_pkg::fra_seg_t I_SEG,
  input wire logic I_SEG_IP_FRAG,
  input wire logic [31:0] I_RCV_LEFT_EDGE,
  // Placement side and status
  input wire logic O_PDU_VALID,
  input wire fra_pkg::fra_pdu_t O_PDU,
  input wire logic I_PDU_READY,
  input wire logic O_DELIVER,
  input wire logic [31:0] O_DELIVER_SEQ,
  input wire logic O_DONT_FRAGMENT,
  input wire logic O_ICMP_FRAG_NEEDED,
  input wire logic O_SACK_HINT,
  input wire logic O_CRC_ERROR,
  input wire logic O_STREAM_FAIL
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESET_N);
  chk_df_set: assert property (O_DONT_FRAGMENT)
    else $error("dont fragment low");
  chk_icmp_frag: assert property (
    I_SEG_VALID && I_SEG.sop && I_SEG_IP_FRAG |=> O_ICMP_FRAG_NEEDED) else $error("no icmp");
  chk_pdu_hold: assert property (
    O_PDU_VALID && !I_PDU_READY |=> O_PDU_VALID && $stable(O_PDU)) else $error("pdu dropped");
  chk_dlv_edge: assert property (
    O_DELIVER |-> $signed($past(I_RCV_LEFT_EDGE) - O_DELIVER_SEQ) >= 0)
    else $error("deliver before edge");
  chk_dlv_pulse: assert property (O_DELIVER |=> !O_DELIVER)
    else $error("deliver too long");
  chk_fail_stick: assert property (O_STREAM_FAIL |=> O_STREAM_FAIL)
    else $error("fail cleared");
  chk_crc_fail: assert property (O_CRC_ERROR |-> ##[0:2] O_STREAM_FAIL)
    else $error("crc without fail");
  chk_sack_cause: assert property (
    O_SACK_HINT |-> $past(I_SEG_VALID) && $past(I_SEG.sop)) else $error("stray sack");
  chk_fail_quiet: assert property (O_STREAM_FAIL |-> !O_PDU_VALID)
    else $error("pdu after fail");
  cov_deliver: cover property (O_DELIVER);
  cov_crc: cover property (O_CRC_ERROR);
  cov_stall: cover property (O_PDU_VALID && !I_PDU_READY);
endmodule // fra_reassembler_props

bind fra_reassembler fra_reassembler_props i_props (
  .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_SEG_VALID(I_SEG_VALID), .I_SEG(I_SEG),
  .I_SEG_IP_FRAG(I_SEG_IP_FRAG), .I_RCV_LEFT_EDGE(I_RCV_LEFT_EDGE),
  .O_PDU_VALID(O_PDU_VALID), .O_PDU(O_PDU), .I_PDU_READY(I_PDU_READY),
  .O_DELIVER(O_DELIVER), .O_DELIVER_SEQ(O_DELIVER_SEQ), .O_DONT_FRAGMENT(O_DONT_FRAGMENT),
  .O_ICMP_FRAG_NEEDED(O_ICMP_FRAG_NEEDED), .O_SACK_HINT(O_SACK_HINT),
  .O_CRC_ERROR(O_CRC_ERROR), .O_STREAM_FAIL(O_STREAM_FAIL));

// File: testbench/fra_sink.sv
// Placement layer model with optional random stalls
`timescale 1ns/1ns
module fra_sink (
  input wire logic i_clk,
  input wire logic i_slow,
  output logic o_ready
);
  initial o_ready = 1'h1;
  // Ready moves only between edges so a held byte is never half taken
  always @(negedge i_clk) begin
    o_ready <= i_slow ? 1'($urandom % 2) : 1'h1;
  end
endmodule // fra_sink

// File: testbench/tb_top.sv
// Self-checking bench for the frame reassembler
`timescale 1ns/1ns
module tb_top;
  localparam logic [31:0] ISN = 32'hFFFFFFF0;
  logic clk = 1'h0, rst_n = 1'h0, seg_valid = 1'h0, ip_frag = 1'h0, ts_en = 1'h0, slow = 1'h0;
  logic [31:0] left_edge = 32'h7FFF0000, wseq = 32'h0, fend, dlv_seq;
  fra_pkg::fra_seg_t seg = '0;
  logic pdu_valid, pdu_ready, deliver, dont_frag, icmp, sack, crc_err, fail;
  fra_pkg::fra_pdu_t pdu;
  fra_pkg::fra_pdu_t exp_q[$];
  logic [31:0] dlv_q[$];
  logic [31:0] fs[$];
  logic [7:0] fd[$];
  int num_errors = 0, compares = 0, cycles = 0, n_icmp = 0, n_sack = 0, n_crc = 0;

  always #5 clk = ~clk;

  fra_reassembler #(.DEPTH(256), .LINK_MTU(200), .MARKER_SPACING(64)) i_dut (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_SEG_VALID(seg_valid), .I_SEG(seg),
    .I_SEG_IP_FRAG(ip_frag), .I_TS_ENABLE(ts_en), .I_RCV_LEFT_EDGE(left_edge),
    .I_MARKER_ENABLE(1'h1), .I_STREAM_ISN(ISN), .O_PDU_VALID(pdu_valid), .O_PDU(pdu),
    .I_PDU_READY(pdu_ready), .O_DELIVER(deliver), .O_DELIVER_SEQ(dlv_seq),
    .O_DONT_FRAGMENT(dont_frag), .O_ICMP_FRAG_NEEDED(icmp), .O_SACK_HINT(sack),
    .O_CRC_ERROR(crc_err), .O_STREAM_FAIL(fail));
  fra_sink i_sink (.i_clk(clk), .i_slow(slow), .o_ready(pdu_ready));

  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_pdu(input fra_pkg::fra_pdu_t e, input fra_pkg::fra_pdu_t g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR pdu byte expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] crc_step(logic [31:0] c, logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ fra_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction

  // Markers are slotted in ahead of any byte that lands on a marker place
  task automatic put(input logic [7:0] b);
    while (((wseq - ISN) & 32'h3F) < 32'h4) begin
      fs.push_back(wseq);
      fd.push_back(8'($urandom));
      wseq++;
    end
    fs.push_back(wseq);
    fd.push_back(b);
    wseq++;
  endtask

  task automatic build(input int len, input bit bad);
    logic [31:0] c;
    logic [7:0] b;
    int pad;
    c = fra_pkg::CRC_INIT;
    pad = (4 - (len + 2) % 4) % 4;
    for (int i = 0; i < len + 2 + pad; i++) begin
      b = (i < len + 2) ? 8'($urandom) : 8'h00;
      if (i < 2)
        b = i ? 8'(len) : 8'(len >> 8);
      c = crc_step(c, b);
      put(b);
      if (!bad && i >= 2 && i < len + 2)
        exp_q.push_back('{first: i == 2, last: i == len + 1, seq: fs[$], data: b});
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 3; i >= 0; i--)
      put(c[8*i +: 8]);
    fend = wseq;
  endtask

  // Mode 1..3 clears one validity flag, mode 4 is a corrupted but valid copy
  task automatic send(input bit rev, input int mode);
    int j;
    for (int i = 0; i < fs.size(); i++) begin
      j = rev ? fs.size() - 1 - i : i;
      @(negedge clk);
      seg_valid = 1'h1;
      seg = '{sop: i == 0, seq: fs[j], data: fd[j] ^ {8{mode != 0}},
             csum_ok: mode != 1, in_window: mode != 2, epoch_ok: mode != 3};
    end
    @(negedge clk);
    seg_valid = 1'h0;
  endtask

  task automatic wait_done();
    int k = 0;
    while ((exp_q.size() + dlv_q.size()) > 0 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk_val("queues left", 32'h0, 32'(exp_q.size() + dlv_q.size()));
  endtask

  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  always @(posedge clk) begin
    if (rst_n && pdu_valid && pdu_ready)
      chk_pdu(exp_q.size() ? exp_q.pop_front() : fra_pkg::fra_pdu_t'('x), pdu);
    if (rst_n && deliver)
      chk_val("deliver seq", dlv_q.size() ? dlv_q.pop_front() : 32'hx, dlv_seq);
    if (rst_n && icmp)
      n_icmp++;
    if (rst_n && sack)
      n_sack++;
    if (rst_n && crc_err)
      n_crc++;
  end

  initial begin
    void'($urandom(32'hDBE2));
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk_val("dont fragment", 32'h1, 32'(dont_frag));
    slow = 1'h1;
    build(6, 0);
    dlv_q.push_back(fend);
    send(0, 0);
    wait_done();
    send(0, 4);
    // Two packed frames crossing a marker, refused copies first, then reversed
    ts_en = 1'h1;
    fs = {};
    fd = {};
    build(20 + $urandom % 21, 0);
    dlv_q.push_back(fend);
    build(20 + $urandom % 21, 0);
    dlv_q.push_back(fend);
    for (int m = 1; m < 4; m++)
      send(1, m);
    send(1, 0);
    send(0, 4);
    wait_done();
    chk_val("sack seen", 32'h3, 32'(n_sack));
    // Empty frame held back by the window edge while a fragment is refused
    fs = {};
    fd = {};
    build(0, 0);
    left_edge = fend - 32'h1;
    send(0, 0);
    @(negedge clk);
    seg_valid = 1'h1;
    ip_frag = 1'h1;
    seg.sop = 1'h1;
    @(negedge clk);
    seg_valid = 1'h0;
    ip_frag = 1'h0;
    repeat (80) @(negedge clk);
    chk_val("icmp count", 32'h1, 32'(n_icmp));
    dlv_q.push_back(fend);
    left_edge = fend;
    wait_done();
    chk_val("early fail", 32'h0, 32'(fail));
    fs = {};
    fd = {};
    build(9, 1);
    send(1, 0);
    repeat (80) @(negedge clk);
    chk_val("crc errors", 32'h1, 32'(n_crc));
    chk_val("stream fail", 32'h1, 32'(fail));
    report_and_stop();
  end
endmodule // tb_top
